// [common/dsp_fmt_pkg.sv]
// constants for the dsp register operand format block
`default_nettype none
package dsp_fmt_pkg;
  // ----------------------------------------
  // register file geometry
  // ----------------------------------------
  localparam int ACC_W    = 40;
  localparam int REG_W    = 32;
  localparam int HALF_W   = 16;
  localparam int GUARD_W  = 8;
  localparam int NUM_REGS = 10;
  localparam int SEL_W    = 4;
  localparam logic [39:0] ACC_RESET = 40'h00_0000_0000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ----------------------------------------
  // register selects
  // ----------------------------------------
  localparam logic [3:0] SEL_ACCUM_ZERO        = 4'h0;
  localparam logic [3:0] SEL_ACCUM_ONE         = 4'h1;
  localparam logic [3:0] SEL_ACCUM_ZERO_GUARD  = 4'h2;
  localparam logic [3:0] SEL_ACCUM_ONE_GUARD   = 4'h3;
  localparam logic [3:0] SEL_XIN_REG_ZERO      = 4'h4;
  localparam logic [3:0] SEL_XIN_REG_ONE       = 4'h5;
  localparam logic [3:0] SEL_YIN_REG_ZERO      = 4'h6;
  localparam logic [3:0] SEL_YIN_REG_ONE       = 4'h7;
  localparam logic [3:0] SEL_MULT_IN_REG_ZERO  = 4'h8;
  localparam logic [3:0] SEL_MULT_IN_REG_ONE   = 4'h9;

  // ----------------------------------------
  // operation classes
  // ----------------------------------------
  localparam logic [2:0] OP_FIXED           = 3'h0;
  localparam logic [2:0] OP_INTEGER         = 3'h1;
  localparam logic [2:0] OP_LOGIC           = 3'h2;
  localparam logic [2:0] OP_MSB_DETECT_OP   = 3'h3;
  localparam logic [2:0] OP_ARITH_SHIFT_OP  = 3'h4;
  localparam logic [2:0] OP_LOGIC_SHIFT_OP  = 3'h5;
  localparam logic [2:0] OP_SIGNED_MUL_OP   = 3'h6;

  // ----------------------------------------
  // transfer kinds
  // ----------------------------------------
  localparam logic [1:0] XFER_XMEM_WORD_MOVE   = 2'h0;
  localparam logic [1:0] XFER_YMEM_WORD_MOVE   = 2'h1;
  localparam logic [1:0] XFER_SINGLE_WORD_MOVE = 2'h2;
  localparam logic [1:0] XFER_SINGLE_LONG_MOVE = 2'h3;
endpackage
`default_nettype wire

// [rtl/dsp_fmt_ext.sv]
// sign or zero extension of a narrow field into a wider word
`default_nettype none
module dsp_fmt_ext #(
  parameter int IN_W  = 16,
  parameter int OUT_W = 40
) (
  input  wire logic [IN_W-1:0]  din,
  input  wire logic             sign_en,
  output logic      [OUT_W-1:0] dout
);
  // a zero-width fill has no legal form, so equal widths are refused too
  if (OUT_W <= IN_W) begin : g_width_check
    $error("dsp_fmt_ext: OUT_W must exceed IN_W");
  end

  always_comb begin
    dout = {{(OUT_W-IN_W){sign_en & din[IN_W-1]}}, din};
  end
endmodule
`default_nettype wire

// [rtl/dsp_reg_fmt.sv]
// dsp data register file with operand alignment and write-back formatting
// What this block does
// RL1: accumulator source for fixed, msb detect, arith shift gives full 40 bits
// RL2: accumulator source for integer gives guard plus upper word, low word zero
// RL3: accumulator source for logic, logic shift, signed multiply uses upper word
// RL4: guard byte register as transfer source supplies only bits 39 to 32
// RL5: input register source for fixed ops is 32 bits sign-extended into guard
// RL6: input register source for integer uses only the upper word
// RL7: input register as long transfer source puts all 32 bits on bus
// RL8: fixed, arith shift, signed multiply result stores 40 bits in accumulator
// RL9: integer and msb detect result writes bits 39 to 16, clears low word
// RL10: logic results into accumulator clear guard, write upper word
// RL11: single word transfer into accumulator loads upper word, sign fills guard; x, y memory word transfers leave it unchanged
// RL12: transfer into guard byte register updates only the guard byte
// RL13: fixed results into input register keep 32 bits, drop guard range
// RL14: integer, logic results into input register write upper word, clear low
// RL15: x transfers into x0, x1, y transfers into y0, y1, word transfers into any input register load the upper word
// RL16: long transfer into input register loads all 32 bits
// RL17: word loads into non-guard registers clear the low word
// RL18: x, y memory word stores come only from accumulator upper words
`default_nettype none
module dsp_reg_fmt (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // arithmetic unit side
  input  wire logic [3:0]  op_src_sel,
  input  wire logic [2:0]  op_class,
  output logic      [39:0] op_operand,
  input  wire logic        res_we,
  input  wire logic [3:0]  res_dst_sel,
  input  wire logic [2:0]  res_class,
  input  wire logic [39:0] res_data,
  // transfer side
  input  wire logic        ld_en,
  input  wire logic [1:0]  ld_kind,
  input  wire logic [3:0]  ld_dst_sel,
  input  wire logic [31:0] ld_data,
  input  wire logic        st_en,
  input  wire logic [1:0]  st_kind,
  input  wire logic [3:0]  st_src_sel,
  output logic      [31:0] st_data,
  output logic             st_valid,
  output logic             st_illegal
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [39:0] acc_q [2];
  logic [39:0] acc_d [2];
  logic [31:0] in_q  [6];
  logic [31:0] in_d  [6];
  logic [39:0] op_operand_d;
  logic [31:0] st_data_d;
  logic        st_valid_d;
  logic        st_illegal_d;

  // ----------------------------------------
  // source selection
  // ----------------------------------------
  logic        src_is_acc;
  logic        src_acc_idx;
  logic [2:0]  src_in_idx;
  logic [39:0] src_acc;
  logic [31:0] src_in;
  logic [39:0] src_in_sx;

  always_comb begin
    src_is_acc  = (op_src_sel == dsp_fmt_pkg::SEL_ACCUM_ZERO) ||
                  (op_src_sel == dsp_fmt_pkg::SEL_ACCUM_ONE);
    src_acc_idx = op_src_sel[0];
    src_in_idx  = 3'(op_src_sel - dsp_fmt_pkg::SEL_XIN_REG_ZERO);
    src_acc     = acc_q[src_acc_idx];
    src_in      = (src_in_idx < 3'h6) ? in_q[src_in_idx] : 32'h0000_0000;
  end

  dsp_fmt_ext #(
    .IN_W  (32),
    .OUT_W (40)
  ) u_src_ext (
    .din     (src_in),
    .sign_en (1'b1),
    .dout    (src_in_sx)
  );

  // ----------------------------------------
  // operand alignment toward the arithmetic unit
  // ----------------------------------------
  always_comb begin
    op_operand_d = 40'h00_0000_0000;
    if (src_is_acc) begin
      unique case (op_class)
        dsp_fmt_pkg::OP_FIXED,
        dsp_fmt_pkg::OP_MSB_DETECT_OP,
        dsp_fmt_pkg::OP_ARITH_SHIFT_OP: op_operand_d = src_acc;                 // [RL1]
        dsp_fmt_pkg::OP_INTEGER:        op_operand_d = {src_acc[39:16], 16'h0000}; // [RL2]
        default:                        op_operand_d = {8'h00, src_acc[31:16], 16'h0000}; // [RL3]
      endcase
    end else begin
      unique case (op_class)
        dsp_fmt_pkg::OP_FIXED,
        dsp_fmt_pkg::OP_MSB_DETECT_OP,
        dsp_fmt_pkg::OP_ARITH_SHIFT_OP: op_operand_d = src_in_sx;               // [RL5]
        // integer keeps the sign in the guard range, the low word is dropped
        dsp_fmt_pkg::OP_INTEGER:        op_operand_d = {src_in_sx[39:16], 16'h0000}; // [RL6]
        default:                        op_operand_d = {8'h00, src_in[31:16], 16'h0000};
      endcase
    end
  end

  // ----------------------------------------
  // write-back of results and loads
  // ----------------------------------------
  logic [23:0] ld_word_hi;
  logic [39:0] ld_word_sx;
  logic [39:0] ld_long_sx;

  dsp_fmt_ext #(
    .IN_W  (16),
    .OUT_W (24)
  ) u_ld_word_ext (
    .din     (ld_data[15:0]),
    .sign_en (1'b1),
    .dout    (ld_word_hi)
  );

  dsp_fmt_ext #(
    .IN_W  (32),
    .OUT_W (40)
  ) u_ld_long_ext (
    .din     (ld_data),
    .sign_en (1'b1),
    .dout    (ld_long_sx)
  );

  always_comb begin
    ld_word_sx = {ld_word_hi, 16'h0000};                                       // [RL17]
  end

  // results are applied first so a same-cycle load to the same register wins;
  // the core never issues both to one register in one cycle
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      acc_d[i] = acc_q[i];
      if (res_we && res_dst_sel == 4'(i)) begin
        unique case (res_class)
          dsp_fmt_pkg::OP_FIXED,
          dsp_fmt_pkg::OP_ARITH_SHIFT_OP,
          dsp_fmt_pkg::OP_SIGNED_MUL_OP:
            acc_d[i] = res_data;                                               // [RL8]
          dsp_fmt_pkg::OP_INTEGER,
          dsp_fmt_pkg::OP_MSB_DETECT_OP:
            acc_d[i] = {res_data[39:16], 16'h0000};                            // [RL9]
          default:
            acc_d[i] = {8'h00, res_data[31:16], 16'h0000};                     // [RL10]
        endcase
      end
      if (ld_en && ld_dst_sel == 4'(i)) begin
        if (ld_kind == dsp_fmt_pkg::XFER_SINGLE_LONG_MOVE) begin
          acc_d[i] = ld_long_sx;
        end else if (ld_kind == dsp_fmt_pkg::XFER_SINGLE_WORD_MOVE) begin
          acc_d[i] = ld_word_sx;                                               // [RL11] [RL17]
        end
      end
      if (ld_en && ld_dst_sel == 4'(i + 2) &&
          (ld_kind == dsp_fmt_pkg::XFER_SINGLE_WORD_MOVE ||
           ld_kind == dsp_fmt_pkg::XFER_SINGLE_LONG_MOVE)) begin
        acc_d[i][39:32] = ld_data[7:0];                                        // [RL12]
      end
    end
    for (int j = 0; j < 6; j++) begin
      in_d[j] = in_q[j];
      if (res_we && res_dst_sel == 4'(j + 4)) begin
        unique case (res_class)
          dsp_fmt_pkg::OP_FIXED,
          dsp_fmt_pkg::OP_ARITH_SHIFT_OP,
          dsp_fmt_pkg::OP_SIGNED_MUL_OP:
            in_d[j] = res_data[31:0];                                          // [RL13]
          default:
            in_d[j] = {res_data[31:16], 16'h0000};                             // [RL14]
        endcase
      end
      if (ld_en && ld_dst_sel == 4'(j + 4)) begin
        if (ld_kind == dsp_fmt_pkg::XFER_SINGLE_LONG_MOVE) begin
          in_d[j] = ld_data;                                                   // [RL16]
        end else if ((ld_kind == dsp_fmt_pkg::XFER_XMEM_WORD_MOVE && j < 2) ||
                     (ld_kind == dsp_fmt_pkg::XFER_YMEM_WORD_MOVE && (j == 2 || j == 3)) ||
                     ld_kind == dsp_fmt_pkg::XFER_SINGLE_WORD_MOVE) begin
          in_d[j] = ld_word_sx[31:0];                                          // [RL15] [RL17]
        end
      end
    end
  end

  // ----------------------------------------
  // store path toward the buses
  // ----------------------------------------
  logic        st_word;
  logic        st_xy;
  logic [39:0] st_acc;

  always_comb begin
    st_word      = (st_kind != dsp_fmt_pkg::XFER_SINGLE_LONG_MOVE);
    st_xy        = (st_kind == dsp_fmt_pkg::XFER_XMEM_WORD_MOVE) ||
                   (st_kind == dsp_fmt_pkg::XFER_YMEM_WORD_MOVE);
    st_acc       = acc_q[st_src_sel[0]];
    st_data_d    = 32'h0000_0000;
    st_valid_d   = 1'b0;
    st_illegal_d = 1'b0;
    if (st_en) begin
      if (st_src_sel <= dsp_fmt_pkg::SEL_ACCUM_ONE) begin
        // word stores sit in the low half of the bus word
        st_data_d  = st_word ? {16'h0000, st_acc[31:16]} : st_acc[31:0];      // [RL18]
        st_valid_d = 1'b1;
      end else if (st_xy || st_src_sel >= 4'(dsp_fmt_pkg::NUM_REGS)) begin
        st_illegal_d = 1'b1;                                                   // [RL18]
      end else if (st_src_sel <= dsp_fmt_pkg::SEL_ACCUM_ONE_GUARD) begin
        st_data_d  = {{24{st_acc[39]}}, st_acc[39:32]};                        // [RL4]
        st_valid_d = 1'b1;
      end else begin
        st_data_d  = st_word ? {16'h0000, in_q[3'(st_src_sel - 4'h4)][31:16]}
                             : in_q[3'(st_src_sel - 4'h4)];                    // [RL7]
        st_valid_d = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q[0]   <= dsp_fmt_pkg::ACC_RESET;
      acc_q[1]   <= dsp_fmt_pkg::ACC_RESET;
      for (int k = 0; k < 6; k++) begin
        in_q[k] <= dsp_fmt_pkg::REG_RESET;
      end
      op_operand <= dsp_fmt_pkg::ACC_RESET;
      st_data    <= dsp_fmt_pkg::REG_RESET;
      st_valid   <= 1'b0;
      st_illegal <= 1'b0;
    end else begin
      acc_q[0]   <= acc_d[0];
      acc_q[1]   <= acc_d[1];
      for (int k = 0; k < 6; k++) begin
        in_q[k] <= in_d[k];
      end
      op_operand <= op_operand_d;
      st_data    <= st_data_d;
      st_valid   <= st_valid_d;
      st_illegal <= st_illegal_d;
    end
  end
endmodule
`default_nettype wire

// [testbench/dsp_alu_model.sv]
// behavioural arithmetic unit standing on the far side of the operand port
`default_nettype none
module dsp_alu_model (
  input  wire logic [39:0] operand,
  output logic      [39:0] result
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // stateless negate
  // ------------------------------
  // answers in the same cycle, so a result can be written back at once
  assign result = 40'h00_0000_0000 - operand;
endmodule
`default_nettype wire

// [testbench/dsp_reg_fmt_asserts.sv]
// port checker for the dsp register operand format block
`default_nettype none
module dsp_reg_fmt_asserts (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [3:0]  op_src_sel,
  input wire logic [2:0]  op_class,
  input wire logic [39:0] op_operand,
  input wire logic        res_we,
  input wire logic        ld_en,
  input wire logic [1:0]  ld_kind,
  input wire logic [3:0]  ld_dst_sel,
  input wire logic [31:0] ld_data,
  input wire logic        st_en,
  input wire logic [1:0]  st_kind,
  input wire logic [3:0]  st_src_sel,
  input wire logic [31:0] st_data,
  input wire logic        st_valid,
  input wire logic        st_illegal
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------
  // operand alignment
  // ------------------------------
  int_low_zero_a:
    assert property (op_class == 3'h1 |=> op_operand[15:0] == 16'h0000)
    else $error("integer operand low word not cleared");
  logic_low_zero_a:
    assert property (op_class inside {3'h2, 3'h5, 3'h6} |=> op_operand[15:0] == 16'h0000)
    else $error("logic operand low word not cleared");
  in_sign_ext_a:
    assert property (op_src_sel inside {[4'h4:4'h9]} && op_class inside {3'h0, 3'h3, 3'h4}
      |=> op_operand[39:32] == {8{op_operand[31]}})
    else $error("input register operand not sign extended");
  acc_word_load_a:
    assert property (ld_en && ld_kind == 2'h2 && ld_dst_sel < 4'h2 ##1 !ld_en && !res_we
      && op_src_sel == $past(ld_dst_sel) && op_class == 3'h0
      |=> op_operand == {{8{$past(ld_data[15], 2)}}, $past(ld_data[15:0], 2), 16'h0000})
    else $error("word load into accumulator misformatted");
  long_load_a:
    assert property (ld_en && ld_kind == 2'h3 && ld_dst_sel inside {[4'h4:4'h9]} ##1 !ld_en
      && !res_we && op_src_sel == $past(ld_dst_sel) && op_class == 3'h0
      |=> op_operand == {{8{$past(ld_data[31], 2)}}, $past(ld_data, 2)})
    else $error("long load into input register misformatted");
  // ------------------------------
  // store path
  // ------------------------------
  store_refuse_a:
    assert property (st_en && !st_kind[1] && st_src_sel > 4'h1 |=> st_illegal && !st_valid)
    else $error("memory word store from non accumulator accepted");
  store_accept_a:
    assert property (st_en && st_src_sel < 4'hA && (st_kind[1] || st_src_sel < 4'h2)
      |=> st_valid && !st_illegal)
    else $error("legal store refused");
  guard_store_a:
    assert property (st_en && st_kind[1] && st_src_sel[3:1] == 3'h1
      |=> st_data[31:8] == {24{st_data[7]}})
    else $error("guard byte store carries more than the guard");
  refuse_c: cover property (st_en ##1 st_illegal);
  word_load_c: cover property (ld_en && ld_kind == 2'h2 && ld_dst_sel < 4'h2);
  guard_load_c: cover property (ld_en && ld_dst_sel[3:1] == 3'h1);
endmodule
bind dsp_reg_fmt dsp_reg_fmt_asserts chk (
  .mclk, .rst_n, .op_src_sel, .op_class, .op_operand, .res_we, .ld_en, .ld_kind,
  .ld_dst_sel, .ld_data, .st_en, .st_kind, .st_src_sel, .st_data, .st_valid, .st_illegal
);
`default_nettype wire

// [testbench/dsp_reg_fmt_tb.sv]
// self-checking bench for the dsp register operand format block
`default_nettype none
module dsp_reg_fmt_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, rst_n, res_we, ld_en, st_en, use_alu, st_valid, st_illegal;
  logic [3:0]  op_src_sel, res_dst_sel, ld_dst_sel, st_src_sel;
  logic [2:0]  op_class, res_class;
  logic [1:0]  ld_kind, st_kind;
  logic [39:0] op_operand, res_drv, res_data, alu_res, g;
  logic [31:0] ld_data, st_data;
  int          mismatches = 0;
  int          checked = 0;
  // ------------------------------
  // tables (selects: 0,1 acc, 2,3 guard, 4..9 x0 x1 y0 y1 m0 m1)
  // ------------------------------
  localparam logic [2:0]  LC [3] = '{3'h2, 3'h5, 3'h6};
  localparam logic [1:0]  WK [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  localparam logic [3:0]  WD [4] = '{4'h4, 4'h7, 4'h9, 4'h6};
  localparam logic [39:0] WE [4] = '{40'hFF_8001_0000, 40'hFF_8001_0000, 40'hFF_8001_0000, 40'h0};
  localparam logic [2:0]  RC [10] = '{3'h0, 3'h4, 3'h6, 3'h1, 3'h3, 3'h2, 3'h5, 3'h0, 3'h1, 3'h6};
  localparam logic [3:0]  RD [10] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h5, 4'h5, 4'h9};
  localparam logic [39:0] RV [10] = '{40'h80_1234_5678, 40'h7F_0000_0001, 40'h00_4000_0000,
    40'h12_3456_789A, 40'h00_0005_FFFF, 40'hFF_3456_789A, 40'h12_8000_0001,
    40'h80_9234_5678, 40'h00_ABCD_1234, 40'h7F_1234_5678};
  localparam logic [39:0] RE [10] = '{40'h80_1234_5678, 40'h7F_0000_0001, 40'h00_4000_0000,
    40'h12_3456_0000, 40'h00_0005_0000, 40'h00_3456_0000, 40'h00_8000_0000,
    40'hFF_9234_5678, 40'hFF_ABCD_0000, 40'h00_1234_5678};
  assign res_data = use_alu ? alu_res : res_drv;
  dsp_reg_fmt dut (.mclk, .rst_n, .op_src_sel, .op_class, .op_operand, .res_we, .res_dst_sel,
    .res_class, .res_data, .ld_en, .ld_kind, .ld_dst_sel, .ld_data, .st_en, .st_kind,
    .st_src_sel, .st_data, .st_valid, .st_illegal);
  dsp_alu_model alu (.operand(op_operand), .result(alu_res));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // ------------------------------
  // drivers
  // ------------------------------
  task automatic chk(input string what, input logic [39:0] e, input logic [39:0] got);
    checked++;
    if (got !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic rd(input logic [3:0] s, input logic [2:0] c);
    op_src_sel = s;
    op_class   = c;
    @(negedge mclk);
    g = op_operand;
  endtask
  // strobes drop on the sampling edge so back-to-back calls never collide
  task automatic ld(input logic [1:0] k, input logic [3:0] d, input logic [31:0] v);
    ld_kind    = k;
    ld_dst_sel = d;
    ld_data    = v;
    ld_en      = 1'b1;
    @(posedge mclk);
    ld_en <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic res(input logic [2:0] c, input logic [3:0] d, input logic [39:0] v);
    res_class   = c;
    res_dst_sel = d;
    res_drv     = v;
    res_we      = 1'b1;
    @(posedge mclk);
    res_we <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic st(input logic [1:0] k, input logic [3:0] s, input logic ok,
                    input logic [31:0] e, input logic [31:0] m);
    st_kind    = k;
    st_src_sel = s;
    st_en      = 1'b1;
    @(posedge mclk);
    st_en <= 1'b0;
    @(negedge mclk);
    chk("st_valid", ok, st_valid);
    chk("st_illegal", !ok, st_illegal);
    if (ok) begin
      chk("st_data", e, st_data & m);
    end
  endtask
  // ------------------------------
  // scenarios
  // ------------------------------
  task automatic t_acc;
    rd(4'h0, 3'h0);
    chk("acc0_reset", 40'h0, g);
    ld(2'h3, 4'h1, 32'h1234_5678);
    ld(2'h2, 4'h3, 32'h0000_00A5);
    rd(4'h1, 3'h0);
    chk("acc1", 40'hA5_1234_5678, g);
    rd(4'h1, 3'h1);
    chk("acc1_int", 40'hA5_1234_0000, g);
    foreach (LC[i]) begin
      rd(4'h1, LC[i]);
      chk("acc1_logic", 40'h00_1234_0000, g);
    end
    st(2'h2, 4'h3, 1'b1, 32'hFFFF_FFA5, 32'hFFFF_FFFF);
    st(2'h3, 4'h3, 1'b1, 32'hFFFF_FFA5, 32'hFFFF_FFFF);
    st(2'h0, 4'h1, 1'b1, 32'h0000_1234, 32'h0000_FFFF);
    ld(2'h3, 4'h0, 32'hFFFF_FFFF);
    ld(2'h2, 4'h0, 32'h0000_8000);
    rd(4'h0, 3'h0);
    chk("acc0_word", 40'hFF_8000_0000, g);
  endtask
  task automatic t_inreg;
    ld(2'h3, 4'h8, 32'h8765_4321);
    rd(4'h8, 3'h0);
    chk("m0", 40'hFF_8765_4321, g);
    rd(4'h8, 3'h1);
    chk("m0_int", 40'h00_8765_0000, {8'h00, g[31:0]});
    st(2'h3, 4'h8, 1'b1, 32'h8765_4321, 32'hFFFF_FFFF);
    st(2'h0, 4'h8, 1'b0, 32'h0, 32'h0);
    st(2'h1, 4'hA, 1'b0, 32'h0, 32'h0);
    ld(2'h3, 4'h4, 32'hFFFF_FFFF);
    foreach (WK[i]) begin
      ld(WK[i], WD[i], 32'h0000_8001);
      rd(WD[i], 3'h0);
      chk("word_load", WE[i], g);
    end
  endtask
  task automatic t_res;
    foreach (RC[i]) begin
      res(RC[i], RD[i], RV[i]);
      rd(RD[i], 3'h0);
      chk("result", RE[i], g);
    end
  endtask
  task automatic t_alu;
    logic [39:0] e;
    e = 40'h00_0000_0000 - 40'hA5_1234_5678;
    rd(4'h1, 3'h0);
    use_alu = 1'b1;
    res(3'h0, 4'h6, 40'h0);
    use_alu = 1'b0;
    rd(4'h6, 3'h0);
    chk("y0_alu", {{8{e[31]}}, e[31:0]}, g);
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    {rst_n, res_we, ld_en, st_en, use_alu} = '0;
    {op_src_sel, op_class, res_dst_sel, res_class, res_drv} = '0;
    {ld_kind, ld_dst_sel, ld_data, st_kind, st_src_sel} = '0;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    t_acc();
    t_inreg();
    t_res();
    t_alu();
    close_out();
  end
  // the whole sequence needs under 60 cycles; this allows over eighty times that
  initial begin
    #40000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire
